// ===== shared/eeprom_spi_map.vh
// Constants for the serial memory front end: opcodes, status layout, protect ranges, timing.
// Included by the serial memory device logic, not by the synchroniser; holds definitions only.
`ifndef EEPROM_SPI_MAP_VH
`define EEPROM_SPI_MAP_VH
`define OP_ENABLE_WRITES   8'h06
`define OP_DISABLE_WRITES  8'h04
`define OP_STATUS_READ     8'h05
`define OP_STATUS_WRITE    8'h01
`define OP_ARRAY_READ      8'h03
`define OP_ARRAY_WRITE     8'h02
`define SR_BUSY_BIT        0
`define SR_WEL_BIT         1
`define SR_BP_LO_BIT       2
`define SR_BP_HI_BIT       3
`define SR_SWD_BIT         7
`define SR_BP_RESET        2'b00
`define SR_SWD_RESET       1'b0
`define PROT_QUARTER_BASE  10'h300
`define PROT_HALF_BASE     10'h200
`define WRITE_CYCLE_NS     5000
`define CLK_PERIOD_NS      20
`define WRITE_CYCLE_CYCLES (`WRITE_CYCLE_NS / `CLK_PERIOD_NS)
`endif

// ===== rtl/pin_sync.v
// Two-flop synchroniser for one pin-level signal.
// Assumes the clock domain of ref_clk; reset value is a parameter.
`timescale 1ns/1ns
module pin_sync #(
   parameter RESET_VAL = 1'b0
) (
   input  wire clk,
   input  wire rst_n,
   input  wire pin,
   output reg  level
);
   reg meta;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta  <= RESET_VAL;
         level <= RESET_VAL;
      end else begin
         meta  <= pin;
         level <= meta;
      end
   end
endmodule // pin_sync

// ===== rtl/serial_eeprom_spi_protect.v
// Serial memory device logic: shifter, pause, select protocol, status and protection.
// Assumes serial pins arrive asynchronously and are oversampled by ref_clk.
//
// Contract
// - Output shifts MSB first on falling edge
// - Input sampled MSB first on rising edge
// - Select high deselects and floats output
// - Pause starts with pause low, clock low
// - Pause ends pause high, clock low; the code also ends it on a clock fall with pause still low
// - Deselect during pause abandons the command
// - After power-up wait for select falling
// - Write needs latch, whole bytes, data
// - Select rise off boundary discards write
// - Reads shift out until select rises
// - Array 1024 bytes, 32 pages of 32
// - Status bits six to four read zero
// - Busy set from accept until cycle ends
// - Enable opcode sets latch; else writes ignored
// - Disable opcode and power-up clear latch
// - Protect bits only via status write
// - Protect encoding rejects writes in range
// - Disable bit zero: status always writable
// - Disable bit one, pin low: frozen
// - Frozen until protect pin returns high
// - Opcode encodings fixed
// - Unknown opcode waits for deselect
// - Status write refused while busy
`timescale 1ns/1ns
`include "eeprom_spi_map.vh"
module serial_eeprom_spi_protect #(
   parameter WRITE_CYCLES = `WRITE_CYCLE_CYCLES,
   parameter ADDR_W       = 10,
   parameter PAGE_W       = 5
) (
   input  wire ref_clk,
   input  wire rst_n,
   input  wire serial_clk,
   input  wire select_n,
   input  wire serial_in,
   input  wire pause_n,
   input  wire write_protect_n,
   output reg  serial_out,
   output reg  serial_out_en
);
   localparam ST_IDLE = 3'd0;
   localparam ST_CMD  = 3'd1;
   localparam ST_ADDR = 3'd2;
   localparam ST_DATA = 3'd3;
   localparam ST_READ = 3'd4;
   localparam ST_WAIT = 3'd5;
   localparam DEPTH   = 1 << ADDR_W;

   reg  [1:0] rst_sync;
   wire       rst_i_n = rst_sync[1];
   wire       sclk_s, sel_s, din_s, pause_s, wp_s;
   reg        sclk_d, sel_d;
   reg        armed;
   reg        paused;
   reg  [2:0] state;
   reg  [2:0] bit_cnt;
   reg  [7:0] shreg;
   reg  [7:0] opcode;
   reg        addr_hi_done;
   reg  [ADDR_W-1:0] addr;
   reg  [7:0] out_byte;
   reg        data_seen;
   reg        write_enable_latch;
   reg  [1:0] bp;
   reg        swd;
   reg        busy;
   reg  [31:0] busy_cnt;
   reg  [7:0] mem [0:DEPTH-1];
   reg  [7:0] page_buf [0:(1<<PAGE_W)-1];
   reg  [(1<<PAGE_W)-1:0] page_mask;
   reg  [ADDR_W-1:0] page_base;
   reg        pend_array;
   reg  [PAGE_W:0] flush_idx;
   reg        pend_status;
   reg  [7:0] status_new;
   reg        en_hold;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   pin_sync #(.RESET_VAL(1'b0)) u_sclk  (.clk(ref_clk), .rst_n(rst_i_n), .pin(serial_clk),
                                          .level(sclk_s));
   pin_sync #(.RESET_VAL(1'b0)) u_sel   (.clk(ref_clk), .rst_n(rst_i_n), .pin(select_n),
                                          .level(sel_s));
   pin_sync #(.RESET_VAL(1'b0)) u_din   (.clk(ref_clk), .rst_n(rst_i_n), .pin(serial_in),
                                          .level(din_s));
   pin_sync #(.RESET_VAL(1'b1)) u_pause (.clk(ref_clk), .rst_n(rst_i_n), .pin(pause_n),
                                          .level(pause_s));
   pin_sync #(.RESET_VAL(1'b1)) u_wp    (.clk(ref_clk), .rst_n(rst_i_n), .pin(write_protect_n),
                                          .level(wp_s));

   wire sclk_rise = sclk_s & ~sclk_d;
   wire sclk_fall = ~sclk_s & sclk_d;
   wire sel_fall  = ~sel_s & sel_d;
   wire sel_rise  = sel_s & ~sel_d;
   wire active    = armed & ~sel_s;
   wire [7:0] next_shreg = {shreg[6:0], din_s};
   wire byte_done = sclk_rise & (bit_cnt == 3'd7);
   wire frozen    = swd & ~wp_s;
   wire [7:0] status_rd = {swd, 3'b000, bp, write_enable_latch, busy};

   function prot_hit;
      input [1:0] f_bp;
      input [ADDR_W-1:0] f_a;
      begin
         case (f_bp)
            2'b01:   prot_hit = (f_a >= `PROT_QUARTER_BASE);
            2'b10:   prot_hit = (f_a >= `PROT_HALF_BASE);
            2'b11:   prot_hit = 1'b1;
            default: prot_hit = 1'b0;
         endcase
      end
   endfunction

   // Serial protocol engine
   always @(posedge ref_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         sclk_d       <= 1'b0;
         sel_d        <= 1'b0;
         armed        <= 1'b0;
         paused       <= 1'b0;
         state        <= ST_IDLE;
         bit_cnt      <= 3'd0;
         shreg        <= 8'h00;
         opcode       <= 8'h00;
         addr_hi_done <= 1'b0;
         addr         <= {ADDR_W{1'b0}};
         out_byte     <= 8'h00;
         data_seen    <= 1'b0;
         write_enable_latch          <= 1'b0;
         bp           <= `SR_BP_RESET;
         swd          <= `SR_SWD_RESET;
         busy         <= 1'b0;
         busy_cnt     <= 32'd0;
         page_mask    <= {(1<<PAGE_W){1'b0}};
         page_base    <= {ADDR_W{1'b0}};
         pend_array   <= 1'b0;
         flush_idx    <= {(PAGE_W+1){1'b0}};
         pend_status  <= 1'b0;
         status_new   <= 8'h00;
         en_hold      <= 1'b0;
         serial_out   <= 1'b0;
         serial_out_en <= 1'b0;
      end else begin
         sclk_d <= sclk_s;
         sel_d  <= sel_s;
         if (sel_fall)
            armed <= 1'b1;
         // Internal write cycle
         if (busy) begin
            if (pend_array) begin
               if (page_mask[flush_idx[PAGE_W-1:0]])
                  mem[page_base | flush_idx[PAGE_W-1:0]] <= page_buf[flush_idx[PAGE_W-1:0]];
               if (flush_idx == (1 << PAGE_W) - 1)
                  pend_array <= 1'b0;
               flush_idx <= flush_idx + 1'b1;
            end
            if (busy_cnt >= WRITE_CYCLES - 1) begin
               busy <= 1'b0;
               if (pend_status) begin
                  swd <= status_new[`SR_SWD_BIT];
                  bp  <= status_new[`SR_BP_HI_BIT:`SR_BP_LO_BIT];
                  pend_status <= 1'b0;
               end
            end else
               busy_cnt <= busy_cnt + 32'd1;
         end
         if (~active) begin
            serial_out_en <= 1'b0;
            paused  <= 1'b0;
            state   <= ST_IDLE;
            bit_cnt <= 3'd0;
            addr_hi_done <= 1'b0;
            data_seen    <= 1'b0;
            if (sel_rise & armed & ~paused & (bit_cnt == 3'd0) & data_seen & write_enable_latch
                & (state == ST_DATA) & ~busy) begin
               write_enable_latch      <= 1'b0;
               busy     <= 1'b1;
               busy_cnt <= 32'd0;
               if (opcode == `OP_STATUS_WRITE) begin
                  pend_status <= 1'b1;
               end else begin
                  pend_array <= 1'b1;
                  flush_idx  <= {(PAGE_W+1){1'b0}};
               end
            end else if (sel_rise & armed & ~paused & (bit_cnt == 3'd0)
                         & (state == ST_WAIT) & ~data_seen) begin
               if (opcode == `OP_ENABLE_WRITES)
                  write_enable_latch <= 1'b1;
               else if (opcode == `OP_DISABLE_WRITES)
                  write_enable_latch <= 1'b0;
            end
         end else if (paused) begin
            if (~sclk_s & (pause_s | sclk_fall)) begin
               paused        <= 1'b0;
               serial_out_en <= en_hold;
            end else
               serial_out_en <= 1'b0;
         end else if (~pause_s & ~sclk_s) begin
            paused        <= 1'b1;
            en_hold       <= serial_out_en;
            serial_out_en <= 1'b0;
         end else begin
            if (sel_fall | (state == ST_IDLE)) begin
               state <= ST_CMD;
               page_mask <= {(1<<PAGE_W){1'b0}};
            end
            if (sclk_rise & (state != ST_WAIT) & (state != ST_READ)) begin
               shreg   <= next_shreg;
               bit_cnt <= bit_cnt + 3'd1;
            end else if (sclk_rise)
               bit_cnt <= bit_cnt + 3'd1;
            if (byte_done) begin
               case (state)
                  ST_CMD: begin
                     opcode <= next_shreg;
                     case (next_shreg)
                        `OP_ENABLE_WRITES, `OP_DISABLE_WRITES: state <= ST_WAIT;
                        `OP_STATUS_READ: begin
                           state    <= ST_READ;
                           out_byte <= status_rd;
                        end
                        `OP_STATUS_WRITE: begin
                           state <= (write_enable_latch & ~busy & ~frozen) ? ST_DATA : ST_WAIT;
                        end
                        `OP_ARRAY_READ, `OP_ARRAY_WRITE: begin
                           if (busy)
                              state <= ST_WAIT;
                           else
                              state <= (next_shreg == `OP_ARRAY_WRITE && !write_enable_latch) ?
                                       ST_WAIT : ST_ADDR;
                        end
                        default: state <= ST_WAIT;
                     endcase
                  end
                  ST_ADDR: begin
                     if (!addr_hi_done) begin
                        addr_hi_done <= 1'b1;
                        addr <= {next_shreg[ADDR_W-9:0], addr[7:0]};
                     end else begin
                        addr <= {addr[ADDR_W-1:8], next_shreg};
                        page_base <= {addr[ADDR_W-1:8], next_shreg} &
                                     ~{{(ADDR_W-PAGE_W){1'b0}}, {PAGE_W{1'b1}}};
                        if (opcode == `OP_ARRAY_READ) begin
                           state    <= ST_READ;
                           out_byte <= mem[{addr[ADDR_W-1:8], next_shreg}];
                           addr     <= {addr[ADDR_W-1:8], next_shreg} + 1'b1;
                        end else
                           state <= prot_hit(bp, {addr[ADDR_W-1:8], next_shreg}) ?
                                    ST_WAIT : ST_DATA;
                     end
                  end
                  ST_DATA: begin
                     data_seen <= 1'b1;
                     if (opcode == `OP_STATUS_WRITE)
                        status_new <= next_shreg;
                     else begin
                        page_buf[addr[PAGE_W-1:0]]  <= next_shreg;
                        page_mask[addr[PAGE_W-1:0]] <= 1'b1;
                        addr <= {addr[ADDR_W-1:PAGE_W], addr[PAGE_W-1:0] + 1'b1};
                     end
                  end
                  ST_READ: begin
                     if (opcode == `OP_STATUS_READ)
                        out_byte <= status_rd;
                     else begin
                        out_byte <= mem[addr];
                        addr     <= addr + 1'b1;
                     end
                  end
                  default: state <= state;
               endcase
            end
            if (sclk_fall & (state == ST_READ)) begin
               serial_out    <= out_byte[3'd7 - bit_cnt];
               serial_out_en <= 1'b1;
            end else if (state != ST_READ)
               serial_out_en <= 1'b0;
         end
      end
   end
endmodule // serial_eeprom_spi_protect

// ===== tb/eeprom_spi_checker.sv
// Pin-level checker for the serial memory device, bound to its top module.
// Assumes one clock domain, ref_clk, with the active-low rst_n.
`timescale 1ns/1ns
module eeprom_spi_checker (
   input wire ref_clk,
   input wire rst_n,
   input wire serial_clk,
   input wire select_n,
   input wire pause_n,
   input wire serial_out,
   input wire serial_out_en
);
   reg       sck_q;
   reg       sel_q;
   reg [3:0] rises;
   // Counts serial clock rises since select last fell
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_q <= 1'b0;
         sel_q <= 1'b0;
         rises <= 4'h0;
      end else begin
         sck_q <= serial_clk;
         sel_q <= select_n;
         if (sel_q && !select_n)
            rises <= 4'h0;
         else if (serial_clk && !sck_q && rises != 4'hf)
            rises <= rises + 4'h1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_desel;
      select_n [*8];
   endsequence
   sequence s_paused;
      (!pause_n && !serial_clk) [*8];
   endsequence
   a_float_desel: assert property (s_desel |-> !serial_out_en)
      else $error("output driven while deselected");
   a_float_pause: assert property (s_paused |-> !serial_out_en)
      else $error("output driven while paused");
   a_reset_quiet: assert property ($rose(rst_n) |-> !serial_out_en [*2])
      else $error("output driven after reset");
   a_opcode_first: assert property (serial_out_en |-> rises >= 4'h8)
      else $error("output driven before a whole byte");
   a_shift_fall: assert property (serial_out_en && $past(serial_out_en) &&
      $changed(serial_out) |-> !$past(serial_clk) && $past(serial_clk, 6))
      else $error("output changed away from a falling clock");
   a_en_start: assert property ($rose(serial_out_en) |->
      !select_n && !$past(serial_clk))
      else $error("output enabled at wrong moment");
   a_en_stop: assert property ($fell(serial_out_en) |-> select_n || !pause_n)
      else $error("output released without cause");
   a_pause_resume: assert property ($rose(pause_n) && !select_n && !serial_clk &&
      $past(serial_out_en, 18) |-> ##[1:8] serial_out_en)
      else $error("output not back after pause");
endmodule // eeprom_spi_checker
bind serial_eeprom_spi_protect eeprom_spi_checker chk_i (
   .ref_clk(ref_clk), .rst_n(rst_n), .serial_clk(serial_clk), .select_n(select_n),
   .pause_n(pause_n), .serial_out(serial_out), .serial_out_en(serial_out_en)
);

// ===== tb/spi_master_model.sv
// Bus master model: clock in mode 0 or 3, select, data out, read capture.
// Assumes 8 ref_clk cycles per bit (160 ns); the data line has no pull.
`timescale 1ns/1ns
module spi_master_model (
   input  wire      ref_clk,
   input  wire      miso,
   input  wire      miso_en,
   output reg       sck,
   output reg       cs_n,
   output reg       mosi
);
   initial begin
      sck  = 1'b0;
      cs_n = 1'b0;
      mosi = 1'b0;
   end
   reg       mode3 = 1'b0;
   reg       last = 1'b0;
   reg [7:0] rx = 8'h00;
   task wt(input integer n);
      repeat (n) @(posedge ref_clk);
   endtask
   task open(input m);
      mode3 = m;
      sck <= m;
      wt(4);
      cs_n <= 1'b0;
      wt(4);
   endtask
   task bits(input integer hi, input integer lo, input [7:0] d);
      integer i;
      for (i = hi; i >= lo; i = i - 1) begin
         sck <= 1'b0;
         mosi <= d[i];
         wt(4);
         sck <= 1'b1;
         wt(4);
         last = (miso_en === 1'b1) ? miso : ~last;
         rx[i] = last;
      end
   endtask
   task close;
      if (!mode3)
         sck <= 1'b0;
      wt(4);
      cs_n <= 1'b1;
      mosi <= ~mosi;
      wt(12);
   endtask
endmodule // spi_master_model

// ===== tb/tb_top.sv
// Bench for the serial memory device: random data, protection and pause cases.
// Assumes 50 MHz ref_clk; the write cycle is lengthened to WC cycles.
`timescale 1ns/1ns
module tb_top;
   localparam WC = 1000;
   reg         ref_clk;
   reg         rst_n;
   reg         pause_n;
   reg         write_protect_n;
   reg  [7:0]  en_cnt;
   reg  [7:0]  n0;
   reg         md = 1'b0;
   reg  [31:0] seed = 32'h0000003a;
   reg  [9:0]  ad [0:2];
   reg  [7:0]  mexp [0:2];
   reg  [7:0]  d;
   integer     err_count = 0;
   integer     comparisons = 0;
   integer     k, j;
   wire        sck, cs_n, mosi, serial_out, serial_out_en;
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      if (!rst_n)
         en_cnt <= 8'h00;
      else if (serial_out_en === 1'b1)
         en_cnt <= en_cnt + 8'h01;
   serial_eeprom_spi_protect #(.WRITE_CYCLES(WC)) DUT (
      .ref_clk(ref_clk), .rst_n(rst_n), .serial_clk(sck), .select_n(cs_n),
      .serial_in(mosi), .pause_n(pause_n), .write_protect_n(write_protect_n),
      .serial_out(serial_out), .serial_out_en(serial_out_en));
   spi_master_model m (.ref_clk(ref_clk), .miso(serial_out), .miso_en(serial_out_en),
      .sck(sck), .cs_n(cs_n), .mosi(mosi));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic bit prot(input logic [1:0] bp, input logic [9:0] a);
      return bp == 2'h3 || (bp == 2'h2 && a >= 10'h200) || (bp == 2'h1 && a >= 10'h300);
   endfunction
   task give_verdict;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task xb(input [7:0] v);
      m.bits(7, 0, v);
   endtask
   task cmd(input [7:0] op);
      m.open(md);
      xb(op);
      m.close;
   endtask
   task stat_rd;
      m.open(md);
      xb(8'h05);
      xb(8'h00);
      m.close;
   endtask
   task st_wr(input [7:0] v);
      cmd(8'h06);
      m.open(md);
      xb(8'h01);
      xb(v);
      m.close;
   endtask
   task mem_wr(input [9:0] a, input [7:0] v, input integer extra, input wen);
      if (wen)
         cmd(8'h06);
      m.open(md);
      xb(8'h02);
      xb({6'h00, a[9:8]});
      xb(a[7:0]);
      xb(v);
      if (extra > 0)
         m.bits(7, 8 - extra, v);
      m.close;
      m.wt(WC + 20);
   endtask
   task mem_rd(input [9:0] a);
      m.open(md);
      xb(8'h03);
      xb({6'h00, a[9:8]});
      xb(a[7:0]);
      xb(8'h00);
      d = m.rx;
      xb(8'h00);
      m.close;
   endtask
   initial begin
      #2000000;
      err_count = err_count + 1;
      give_verdict;
   end
   initial begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      pause_n = 1'b1;
      write_protect_n = 1'b1;
      ad[0] = 10'h000;
      ad[1] = 10'h2ff;
      ad[2] = 10'h3ff;
      m.wt(16);
      rst_n <= 1'b1;
      m.wt(8);
      xb(8'h05);
      xb(8'h00);
      m.close;
      chk("unselected", en_cnt, 8'h00);
      stat_rd;
      chk("status reset", m.rx, 8'h00);
      cmd(8'h06);
      stat_rd;
      chk("latch set", m.rx, 8'h02);
      cmd(8'h04);
      stat_rd;
      chk("latch clear", m.rx, 8'h00);
      n0 = en_cnt;
      m.open(md);
      xb(8'hff);
      xb(8'h05);
      xb(8'h00);
      m.close;
      chk("bad opcode", en_cnt - n0, 8'h00);
      for (k = 0; k < 4; k = k + 1) begin
         md = k[0];
         st_wr({4'h0, k[1:0], 2'b00});
         stat_rd;
         chk("busy", m.rx & 8'h01, 8'h01);
         st_wr(8'h8c);
         m.wt(WC);
         stat_rd;
         chk("protect bits", m.rx & 8'hfd, {4'h0, k[1:0], 2'b00});
         for (j = 0; j < 3; j = j + 1) begin
            seed = xs(seed);
            mem_wr(ad[j], seed[7:0], 0, 1'b1);
            if (!prot(k[1:0], ad[j]))
               mexp[j] = seed[7:0];
         end
         for (j = 0; j < 3; j = j + 1) begin
            mem_rd(ad[j]);
            chk("array", d, mexp[j]);
         end
         chk("wrap", m.rx, mexp[0]);
      end
      write_protect_n <= 1'b0;
      st_wr(8'h80);
      m.wt(WC);
      stat_rd;
      chk("pin low writable", m.rx, 8'h80);
      m.open(md);
      xb(8'h05);
      m.bits(7, 5, 8'h00);
      m.sck <= 1'b0;
      m.wt(6);
      pause_n <= 1'b0;
      m.mosi <= ~m.mosi;
      m.wt(16);
      pause_n <= 1'b1;
      m.wt(4);
      m.bits(4, 0, 8'h00);
      m.close;
      chk("paused read", m.rx, 8'h80);
      st_wr(8'h84);
      m.wt(WC);
      stat_rd;
      chk("frozen", m.rx, 8'h82);
      write_protect_n <= 1'b1;
      st_wr(8'h00);
      m.wt(WC);
      stat_rd;
      chk("unfrozen", m.rx, 8'h00);
      seed = xs(seed);
      mem_wr(ad[0], seed[7:0], 3, 1'b1);
      cmd(8'h04);
      mem_wr(ad[0], seed[7:0], 0, 1'b0);
      cmd(8'h06);
      m.open(md);
      xb(8'h02);
      xb(8'h00);
      xb(8'h00);
      xb(seed[7:0]);
      m.sck <= 1'b0;
      m.wt(4);
      pause_n <= 1'b0;
      m.wt(8);
      m.cs_n <= 1'b1;
      m.wt(8);
      pause_n <= 1'b1;
      m.wt(WC);
      mem_rd(ad[0]);
      chk("discarded", d, mexp[0]);
      give_verdict;
   end
endmodule // tb_top
